// [src/ties_pkg.sv]
// constants and types of the timer interrupt enable and status block
package ties_pkg;
    localparam logic [3:0] TIES_OFF_IE = 4'h0;
    localparam logic [3:0] TIES_OFF_FLAGS = 4'h4;
    localparam logic [3:0] TIES_OFF_CTRL = 4'h8;
    localparam logic [7:0] TIES_IE_RST = 8'h01;
    localparam logic [7:0] TIES_FLAGS_RST = 8'h00;
    localparam logic [7:0] TIES_CTRL_RST = 8'h00;
    localparam logic [7:0] TIES_IE_WMASK = 8'hfe;
    localparam logic [15:0] TIES_CNT_MAX = 16'hffff;
    localparam logic [15:0] TIES_CNT_ZERO = 16'h0000;
    localparam logic [15:0] TIES_CAP_RST = 16'h0000;
    localparam int TIES_CLR_BIT = 0;
    localparam int TIES_RSV_BIT = 0;
    localparam int TIES_EDGE_A_BIT = 7;
    localparam int TIES_EDGE_B_BIT = 6;
    localparam int TIES_EDGE_C_BIT = 5;
    localparam int TIES_EDGE_D_BIT = 4;
    localparam int TIES_BUF_A_BIT = 3;
    localparam int TIES_BUF_B_BIT = 2;

    // seven events, bit 6 = capture a ... bit 0 = counter wrap
    typedef struct packed {
        logic capture_a;
        logic capture_b;
        logic capture_c;
        logic capture_d;
        logic compare_a;
        logic compare_b;
        logic counter_wrap;
    } ties_evt_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } ties_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } ties_avs_rsp_t;
endpackage

// [src/ties_top.sv]
// timer interrupt enables, event flags and counter clear option
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module ties_top
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic standby_i,
    input wire ties_pkg::ties_avs_req_t avs_req_i,
    output ties_pkg::ties_avs_rsp_t avs_rsp_o,
    input wire logic [15:0] free_running_count_i,
    input wire logic [15:0] compare_value_a_i,
    input wire logic [15:0] compare_value_b_i,
    input wire logic capture_a_pin_i,
    input wire logic capture_b_pin_i,
    input wire logic capture_c_pin_i,
    input wire logic capture_d_pin_i,
    output logic [15:0] capture_value_a_o,
    output logic [15:0] capture_value_b_o,
    output logic [15:0] capture_value_c_o,
    output logic [15:0] capture_value_d_o,
    output logic counter_clear_o,
    output logic clear_on_compare_a_o,
    output ties_pkg::ties_evt_t irq_req_o,
    output logic irq_o
);
    import ties_pkg::*;

    logic init;
    logic ack_r;
    logic take;
    logic rd_take;
    logic wr_take;
    logic [31:0] rdata_r;
    logic [7:0] ie_r;
    logic [7:0] ctrl_r;
    logic [6:0] flags_r;
    logic [6:0] flags_nxt;
    logic [6:0] armed_r;
    logic clr_on_a_r;
    logic [6:0] evt;
    logic [6:0] en;
    logic [6:0] wclr;
    logic [3:0] pin;
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] cap_evt;
    logic [15:0] prev_cnt_r;
    logic match_a;
    logic match_b;
    logic match_a_r;
    logic match_b_r;
    logic buf_a;
    logic buf_b;

    assign init = sys_rst_i | standby_i;
    assign buf_a = ctrl_r[TIES_BUF_A_BIT];
    assign buf_b = ctrl_r[TIES_BUF_B_BIT];

    // bus slave: one wait cycle, answer at second edge
    assign take = (avs_req_i.read | avs_req_i.write) & ack_r;
    assign rd_take = take & avs_req_i.read;
    assign wr_take = take & avs_req_i.write & avs_req_i.byteenable[0];
    assign avs_rsp_o.waitrequest = (avs_req_i.read | avs_req_i.write) & ~ack_r;
    assign avs_rsp_o.readdata = rdata_r;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= (avs_req_i.read | avs_req_i.write) & ~ack_r;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            rdata_r <= '0;
        else if (avs_req_i.read & ~ack_r)
        begin
            unique case (avs_req_i.address)
                TIES_OFF_IE: rdata_r <= {24'h000000, ie_r};
                TIES_OFF_FLAGS: rdata_r <= {24'h000000, flags_r, clr_on_a_r};
                TIES_OFF_CTRL: rdata_r <= {24'h000000, ctrl_r};
                default: rdata_r <= '0;
            endcase
        end
    end

    // enable register, bit 0 fixed
    always_ff @(posedge core_clk_i)
    begin
        if (init)
            ie_r <= TIES_IE_RST;
        else if (wr_take && avs_req_i.address == TIES_OFF_IE)
            ie_r <= (avs_req_i.writedata[7:0] & TIES_IE_WMASK) | TIES_IE_RST;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (init)
            ctrl_r <= TIES_CTRL_RST;
        else if (wr_take && avs_req_i.address == TIES_OFF_CTRL)
            ctrl_r <= avs_req_i.writedata[7:0];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (init)
            clr_on_a_r <= TIES_FLAGS_RST[TIES_CLR_BIT];
        else if (wr_take && avs_req_i.address == TIES_OFF_FLAGS)
            clr_on_a_r <= avs_req_i.writedata[TIES_CLR_BIT];
    end
    assign clear_on_compare_a_o = clr_on_a_r;

    // capture pins: two-flop sync, third flop for edges
    assign pin = {capture_a_pin_i, capture_b_pin_i, capture_c_pin_i, capture_d_pin_i};
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // edge select: 1 rising, 0 falling
    assign cap_evt = (s2_r ^ s3_r) & ~(s2_r ^ ctrl_r[7:4]);

    // capture registers
    always_ff @(posedge core_clk_i)
    begin
        if (init)
        begin
            capture_value_a_o <= TIES_CAP_RST;
            capture_value_c_o <= TIES_CAP_RST;
        end
        else
        begin
            if (cap_evt[3])
                capture_value_a_o <= free_running_count_i;
            if (cap_evt[3] && buf_a)
                capture_value_c_o <= capture_value_a_o;
            else if (cap_evt[1] && !buf_a)
                capture_value_c_o <= free_running_count_i;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (init)
        begin
            capture_value_b_o <= TIES_CAP_RST;
            capture_value_d_o <= TIES_CAP_RST;
        end
        else
        begin
            if (cap_evt[2])
                capture_value_b_o <= free_running_count_i;
            if (cap_evt[2] && buf_b)
                capture_value_d_o <= capture_value_b_o;
            else if (cap_evt[0] && !buf_b)
                capture_value_d_o <= free_running_count_i;
        end
    end

    // compare and wrap detection
    assign match_a = free_running_count_i == compare_value_a_i;
    assign match_b = free_running_count_i == compare_value_b_i;
    always_ff @(posedge core_clk_i)
    begin
        if (init)
        begin
            prev_cnt_r <= TIES_CNT_ZERO;
            match_a_r <= 1'b0;
            match_b_r <= 1'b0;
        end
        else
        begin
            prev_cnt_r <= free_running_count_i;
            match_a_r <= match_a;
            match_b_r <= match_b;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (init)
            counter_clear_o <= 1'b0;
        else
            counter_clear_o <= match_a & ~match_a_r & clr_on_a_r;
    end

    assign evt[6:3] = cap_evt;
    assign evt[2] = match_a & ~match_a_r;
    assign evt[1] = match_b & ~match_b_r;
    assign evt[0] = (prev_cnt_r == TIES_CNT_MAX) && (free_running_count_i == TIES_CNT_ZERO);

    // zero written to an armed flag clears it; ones are ignored
    assign wclr = (wr_take && avs_req_i.address == TIES_OFF_FLAGS) ?
                  (~avs_req_i.writedata[7:1] & armed_r) : 7'h00;
    assign flags_nxt = (flags_r & ~wclr) | evt;

    always_ff @(posedge core_clk_i)
    begin
        if (init)
            flags_r <= TIES_FLAGS_RST[7:1];
        else
            flags_r <= flags_nxt;
    end

    // arm flags that a read saw as one
    always_ff @(posedge core_clk_i)
    begin
        if (init)
            armed_r <= '0;
        else if (rd_take && avs_req_i.address == TIES_OFF_FLAGS)
            armed_r <= armed_r | rdata_r[7:1];
        else if (wr_take && avs_req_i.address == TIES_OFF_FLAGS)
            armed_r <= '0;
    end

    // request levels
    assign en = ie_r[7:1];
    assign irq_req_o = ties_evt_t'(flags_r & en);
    assign irq_o = |(flags_r & en);

    property p_ie_read_one;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (rd_take && avs_req_i.address == TIES_OFF_IE) |-> avs_rsp_o.readdata[TIES_RSV_BIT];
    endproperty
    a_ie_read_one: assert property (p_ie_read_one)
        else $error("enable bit 0 read as zero");

    property p_init_vals;
        @(posedge core_clk_i)
        $past(standby_i) && !$past(sys_rst_i) |-> ie_r == TIES_IE_RST && flags_r == '0;
    endproperty
    a_init_vals: assert property (p_init_vals)
        else $error("standby did not restore reset values");

    property p_no_sw_set;
        @(posedge core_clk_i) disable iff (sys_rst_i || standby_i)
        ##1 (flags_r & ~$past(flags_r) & ~$past(evt)) == 7'h00;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set)
        else $error("flag set without an event");

    property p_clear_after_read;
        @(posedge core_clk_i) disable iff (sys_rst_i || standby_i)
        ##1 ($past(flags_r) & ~flags_r & ~$past(armed_r)) == 7'h00;
    endproperty
    a_clear_after_read: assert property (p_clear_after_read)
        else $error("flag cleared without a prior read");

    property p_wrap;
        @(posedge core_clk_i) disable iff (init)
        (prev_cnt_r == TIES_CNT_MAX && free_running_count_i == TIES_CNT_ZERO)
        |=> flags_r[0] && irq_req_o.counter_wrap == ie_r[1];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap flag or request missing");

    property p_cmp_a;
        @(posedge core_clk_i) disable iff (init)
        $rose(match_a) |=> flags_r[2] && counter_clear_o == $past(clr_on_a_r);
    endproperty
    a_cmp_a: assert property (p_cmp_a)
        else $error("compare a match lost");

    property p_cap_a;
        @(posedge core_clk_i) disable iff (init)
        cap_evt[3] |=> capture_value_a_o == $past(free_running_count_i) && flags_r[6];
    endproperty
    a_cap_a: assert property (p_cap_a)
        else $error("capture a did not store count");

    property p_buf_a;
        @(posedge core_clk_i) disable iff (init)
        cap_evt[3] && buf_a |=> capture_value_c_o == $past(capture_value_a_o);
    endproperty
    a_buf_a: assert property (p_buf_a)
        else $error("buffered capture a did not shift into c");

    property p_c_plain;
        @(posedge core_clk_i) disable iff (init)
        cap_evt[1] && buf_a && !cap_evt[3] |=> $stable(capture_value_c_o) && flags_r[4];
    endproperty
    a_c_plain: assert property (p_c_plain)
        else $error("capture c stored count in buffer mode");

    property p_edge_sel;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cap_evt[3] |-> s2_r[3] == ctrl_r[TIES_EDGE_A_BIT] && s3_r[3] != s2_r[3];
    endproperty
    a_edge_sel: assert property (p_edge_sel)
        else $error("capture a on wrong edge");

    property p_irq_gate;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        irq_o == (irq_req_o != 7'h00) && (irq_req_o & ~ie_r[7:1]) == 7'h00;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request without enable");

    property p_set_wins;
        @(posedge core_clk_i) disable iff (init)
        evt != 7'h00 |=> (flags_r & $past(evt)) == $past(evt);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("hardware event lost against a clear");

    property p_no_clr;
        @(posedge core_clk_i) disable iff (init)
        !clr_on_a_r |=> !counter_clear_o;
    endproperty
    a_no_clr: assert property (p_no_clr)
        else $error("count cleared with clear option off");

    property p_cmp_b;
        @(posedge core_clk_i) disable iff (init)
        $rose(match_b) |=> flags_r[1];
    endproperty
    a_cmp_b: assert property (p_cmp_b)
        else $error("compare b match lost");
endmodule

// [tb/tb_timer_irq_enable_status.sv]
// self-checking bench for the timer interrupt enable and flag block
`timescale 1ns/1ps
module tb_timer_irq_enable_status;
    import ties_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic standby_i = 1'b0;
    ties_avs_req_t req = '0;
    ties_avs_rsp_t rsp;
    logic [15:0] cnt = 16'h0000;
    logic [15:0] cmp_a = 16'hc000;
    logic [15:0] cmp_b = 16'hd000;
    logic [3:0] pins = 4'hf;
    logic [15:0] cap_a, cap_b, cap_c, cap_d;
    logic clr_pulse, clr_opt, irq;
    ties_evt_t irq_req;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int clr_seen = 0;
    integer seed = 32'hb98d;
    logic [7:0] d, r, fl;
    logic [15:0] c1, c2;

    ties_top dut_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .standby_i(standby_i),
        .avs_req_i(req), .avs_rsp_o(rsp), .free_running_count_i(cnt),
        .compare_value_a_i(cmp_a), .compare_value_b_i(cmp_b),
        .capture_a_pin_i(pins[3]), .capture_b_pin_i(pins[2]),
        .capture_c_pin_i(pins[1]), .capture_d_pin_i(pins[0]),
        .capture_value_a_o(cap_a), .capture_value_b_o(cap_b),
        .capture_value_c_o(cap_c), .capture_value_d_o(cap_d),
        .counter_clear_o(clr_pulse), .clear_on_compare_a_o(clr_opt),
        .irq_req_o(irq_req), .irq_o(irq));

    initial
    begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task stop_test;
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge core_clk_i)
    begin
        cyc++;
        if (clr_pulse === 1'b1)
            clr_seen++;
        if (cyc == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] exp_ie(input logic [7:0] v);
        exp_ie = v | 8'h01;
    endfunction

    task wr(input logic [3:0] a, input logic [7:0] v);
        req.address <= a;
        req.byteenable <= 4'h1;
        req.writedata <= {24'h0, v};
        req.write <= 1'b1;
        do @(posedge core_clk_i); while (rsp.waitrequest !== 1'b0);
        req.write <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task rd(input logic [3:0] a, output logic [7:0] v);
        req.address <= a;
        req.read <= 1'b1;
        do @(posedge core_clk_i); while (rsp.waitrequest !== 1'b0);
        v = rsp.readdata[7:0];
        req.read <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task pin(input int i, input logic v);
        pins[i] <= v;
        repeat (6) @(posedge core_clk_i);
    endtask

    task count_to(input logic [15:0] v);
        cnt <= v;
        repeat (3) @(posedge core_clk_i);
    endtask

    task chk_flags;
        rd(TIES_OFF_FLAGS, r);
        check(r, fl);
    endtask

    initial
    begin
        repeat (12) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        rd(TIES_OFF_IE, r);
        check(r, 8'h01);
        rd(TIES_OFF_FLAGS, r);
        check(r, 8'h00);
        rd(4'hc, r);
        check(r, 8'h00);
        wr(TIES_OFF_IE, 8'h00);
        rd(TIES_OFF_IE, r);
        check(r, 8'h01);
        repeat (8)
        begin
            d = 8'($random(seed));
            wr(TIES_OFF_IE, d);
            rd(TIES_OFF_IE, r);
            check(r, exp_ie(d));
        end
        wr(TIES_OFF_IE, 8'h01);
        fl = 8'h00;
        wr(TIES_OFF_FLAGS, 8'hfe);
        chk_flags();
        fl = 8'h01;
        wr(TIES_OFF_FLAGS, 8'h01);
        chk_flags();
        check(clr_opt, 1'b1);
        count_to(16'hc000);
        count_to(16'hc001);
        check(clr_seen, 1);
        fl[3] = 1'b1;
        chk_flags();
        count_to(16'hd000);
        fl[2] = 1'b1;
        chk_flags();
        count_to(16'hffff);
        count_to(16'h0000);
        fl[1] = 1'b1;
        chk_flags();
        c1 = 16'h0100 | (16'($random(seed)) & 16'h3fff);
        c2 = 16'h4000 | (16'($random(seed)) & 16'h3fff);
        count_to(c1);
        pin(3, 1'b0);
        check(cap_a, c1);
        pin(3, 1'b1);
        count_to(c2);
        pin(3, 1'b0);
        check(cap_a, c2);
        pin(1, 1'b0);
        check(cap_c, c2);
        wr(TIES_OFF_CTRL, 8'h48);
        pin(3, 1'b1);
        count_to(c1);
        pin(3, 1'b0);
        check({cap_a, cap_c}, {c1, c2});
        pin(1, 1'b1);
        pin(1, 1'b0);
        check(cap_c, c2);
        pin(0, 1'b0);
        check(cap_d, c1);
        pin(2, 1'b0);
        check(cap_b, 16'h0000);
        pin(2, 1'b1);
        check(cap_b, c1);
        fl[7:4] = 4'hf;
        check(irq_req, 7'h00);
        wr(TIES_OFF_IE, 8'hff);
        check(irq_req, 7'h7f);
        check(irq, 1'b1);
        wr(TIES_OFF_FLAGS, 8'h00);
        fl = 8'hf0;
        chk_flags();
        check(irq_req, 7'h78);
        wr(TIES_OFF_IE, 8'h01);
        check(irq, 1'b0);
        wr(TIES_OFF_FLAGS, 8'h0f);
        fl = 8'h01;
        chk_flags();
        standby_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        standby_i <= 1'b0;
        @(posedge core_clk_i);
        rd(TIES_OFF_IE, r);
        check(r, 8'h01);
        rd(TIES_OFF_FLAGS, r);
        check(r, 8'h00);
        check(cap_a, 16'h0000);
        stop_test();
    end
endmodule
